// ---- src/sdra_map.vh ----
`ifndef SDRA_MAP_VH
`define SDRA_MAP_VH

// System clock rate in Hz (10 MHz)
`define SDRA_CLK_HZ 25'h098_9680

// Modulator sample rates in Hz for the internal oscillator
`define SDRA_FS_50HZ 25'h000_3200
`define SDRA_FS_5060HZ 25'h000_3688
`define SDRA_FS_60HZ 25'h000_3C00

// Notch selection codes
`define SDRA_NOTCH_5060 2'h0
`define SDRA_NOTCH_50 2'h1
`define SDRA_NOTCH_60 2'h2

// Sample rate relations: fs = 256 * notch = 2048 * single-speed output rate
`define SDRA_NOTCH_RATIO 12'h100
`define SDRA_OUT_RATIO 12'h800

// External conversion clock periods per modulator sample
`define SDRA_EXT_DIV 5'h14

// External conversion clock periods per full conversion phase
`define SDRA_EXT_CONV_CYCLES 16'hA04C

// Result saturation at 150 percent of one half-window full scale
`define SDRA_FS_CODE 13'h0400
`define SDRA_SAT_CODE 13'h0600

`endif

// ---- src/sdra_skid_buf.v ----
`timescale 1ns/10ps
// Two-entry buffer; both output flags and data come straight from registers
module sdra_skid_buf #(
  parameter W = 14
) (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_valid,
  output reg o_ready,
  input wire [W-1:0] i_data,
  output reg o_valid,
  input wire i_ready,
  output reg [W-1:0] o_data
);
  reg skid_valid;
  reg [W-1:0] skid_data;

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_data <= {W{1'b0}};
      skid_valid <= 1'b0;
      skid_data <= {W{1'b0}};
      o_ready <= 1'b1;
    end else begin
      if (i_ready || !o_valid) begin
        if (skid_valid) begin
          o_valid <= 1'b1;
          o_data <= skid_data;
          skid_valid <= 1'b0;
          o_ready <= 1'b1;
        end else begin
          o_valid <= i_valid && o_ready;
          if (i_valid && o_ready) begin
            o_data <= i_data;
          end
        end
      end else if (i_valid && o_ready) begin
        // Receiver stalled: park the word so nothing is lost
        skid_data <= i_data;
        skid_valid <= 1'b1;
        o_ready <= 1'b0;
      end
    end
  end
endmodule // sdra_skid_buf

// ---- src/sdra_decimator.v ----
`timescale 1ns/10ps
`include "sdra_map.vh"
module sdra_decimator #(
  parameter [15:0] EXT_CONV_CYCLES = `SDRA_EXT_CONV_CYCLES
) (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_mod_bit,
  input wire i_ext_clk,
  input wire i_ext_clk_sel,
  input wire [1:0] i_notch_sel,
  input wire i_double_speed,
  output reg o_mod_sample,
  output reg o_cal_phase,
  output wire o_result_valid,
  input wire i_result_ready,
  output wire [12:0] o_result_data,
  output wire o_over_range
);
  localparam ST_CAL = 2'b00;
  localparam ST_SIG = 2'b01;
  localparam ST_HOLD = 2'b10;
  localparam [11:0] HALF_SAMPLES = `SDRA_OUT_RATIO >> 1;
  localparam [15:0] EXT_HALF = EXT_CONV_CYCLES >> 1;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [24:0] phase;
  reg [24:0] rate;
  reg int_tick;
  reg ext_sync1;
  reg ext_sync2;
  reg ext_sync3;
  reg [4:0] ext_div;
  reg ext_tick;
  reg edge_dly1;
  reg edge_dly2;
  reg [15:0] ext_phase;
  reg [11:0] samp_cnt;
  reg signed [12:0] acc;
  reg signed [12:0] offset;
  reg signed [12:0] prev_raw;
  reg hist_valid;
  reg [3:0] cfg;
  reg signed [12:0] pend_data;
  reg pend_over;
  reg signed [12:0] acc_now;
  reg signed [13:0] diff;
  reg signed [13:0] sum;
  reg signed [12:0] res;
  reg res_over;
  reg win_end;
  wire [24:0] phase_sum;
  wire ext_edge;
  wire buf_ready;
  wire push;
  wire cfg_change;
  wire [13:0] buf_out;

  assign phase_sum = phase + rate;
  assign ext_edge = ext_sync2 & ~ext_sync3;
  assign cfg_change = (cfg != {i_ext_clk_sel, i_notch_sel, i_double_speed});
  assign push = (state == ST_HOLD) && !cfg_change;
  assign o_result_data = buf_out[12:0];
  assign o_over_range = buf_out[13];

  always @* begin
    case (i_notch_sel)
      `SDRA_NOTCH_50: rate = `SDRA_FS_50HZ;
      `SDRA_NOTCH_60: rate = `SDRA_FS_60HZ;
      default: rate = `SDRA_FS_5060HZ;
    endcase
  end

  // Fractional accumulator keeps the mean sample rate exact at 10 MHz
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      phase <= 25'h000_0000;
      int_tick <= 1'b0;
    end else if (phase_sum >= `SDRA_CLK_HZ) begin
      phase <= phase_sum - `SDRA_CLK_HZ;
      int_tick <= 1'b1;
    end else begin
      phase <= phase_sum;
      int_tick <= 1'b0;
    end
  end

  // External clock is asynchronous: two flops, then the edge detector
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
      ext_sync3 <= 1'b0;
      ext_div <= 5'h00;
      ext_tick <= 1'b0;
      edge_dly1 <= 1'b0;
      edge_dly2 <= 1'b0;
    end else begin
      ext_sync1 <= i_ext_clk;
      ext_sync2 <= ext_sync1;
      ext_sync3 <= ext_sync2;
      ext_tick <= 1'b0;
      // Edge delayed to meet its own sample pulse, so a window never splits an edge from its sample
      edge_dly1 <= ext_edge;
      edge_dly2 <= edge_dly1;
      if (ext_edge) begin
        if (ext_div == `SDRA_EXT_DIV - 5'h01) begin
          ext_div <= 5'h00;
          ext_tick <= 1'b1;
        end else begin
          ext_div <= ext_div + 5'h01;
        end
      end
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_mod_sample <= 1'b0;
    end else begin
      o_mod_sample <= i_ext_clk_sel ? ext_tick : int_tick;
    end
  end

  always @* begin
    acc_now = acc;
    if (o_mod_sample && (state != ST_HOLD)) begin
      acc_now = i_mod_bit ? acc + 13'sh0001 : acc - 13'sh0001;
    end
    // A half window is 1024 samples internally, half of 41036 periods externally
    if (i_ext_clk_sel) begin
      win_end = edge_dly2 && (ext_phase == EXT_HALF - 16'h0001);
    end else begin
      win_end = o_mod_sample && (samp_cnt == HALF_SAMPLES - 12'h001);
    end
    if (state == ST_HOLD) begin
      win_end = 1'b0;
    end
    // Calibrated or raw result before averaging
    // Both arms signed, so negative values extend with their sign
    diff = i_double_speed ? $signed({acc_now[12], acc_now}) : acc_now - offset;
    sum = (i_double_speed && hist_valid) ? acc_now + prev_raw : $signed({diff[12:0], 1'b0});
    if (i_double_speed) begin
      diff = sum >>> 1;
    end
    res_over = (diff > $signed({1'b0, `SDRA_FS_CODE})) ||
               (diff < -$signed({1'b0, `SDRA_FS_CODE}));
    if (diff > $signed({1'b0, `SDRA_SAT_CODE})) begin
      res = `SDRA_SAT_CODE;
    end else if (diff < -$signed({1'b0, `SDRA_SAT_CODE})) begin
      res = -$signed(`SDRA_SAT_CODE);
    end else begin
      res = diff[12:0];
    end
    next_state = state;
    case (state)
      ST_CAL: begin
        if (win_end) begin
          next_state = ST_SIG;
        end
      end
      ST_SIG: begin
        if (win_end) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (buf_ready) begin
          next_state = i_double_speed ? ST_SIG : ST_CAL;
        end
      end
      default: next_state = ST_CAL;
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      state <= ST_CAL;
      cfg <= 4'h0;
      acc <= 13'sh0000;
      offset <= 13'sh0000;
      prev_raw <= 13'sh0000;
      hist_valid <= 1'b0;
      samp_cnt <= 12'h000;
      ext_phase <= 16'h0000;
      pend_data <= 13'sh0000;
      pend_over <= 1'b0;
      o_cal_phase <= 1'b1;
    end else if (cfg_change) begin
      // Restart so no window mixes samples from two settings
      cfg <= {i_ext_clk_sel, i_notch_sel, i_double_speed};
      state <= i_double_speed ? ST_SIG : ST_CAL;
      o_cal_phase <= !i_double_speed;
      acc <= 13'sh0000;
      hist_valid <= 1'b0;
      samp_cnt <= 12'h000;
      ext_phase <= 16'h0000;
    end else begin
      state <= next_state;
      o_cal_phase <= (next_state == ST_CAL);
      if (win_end || (state == ST_HOLD)) begin
        acc <= 13'sh0000;
        samp_cnt <= 12'h000;
        ext_phase <= 16'h0000;
      end else begin
        acc <= acc_now;
        if (o_mod_sample) begin
          samp_cnt <= samp_cnt + 12'h001;
        end
        if (edge_dly2) begin
          ext_phase <= ext_phase + 16'h0001;
        end
      end
      if (win_end && (state == ST_CAL)) begin
        offset <= acc_now;
      end
      if (win_end && (state == ST_SIG)) begin
        pend_data <= res;
        pend_over <= res_over;
        prev_raw <= acc_now;
        hist_valid <= i_double_speed;
      end
    end
  end

  // Conversion waits in hold while the receiver stalls, so no result is dropped
  sdra_skid_buf #(
    .W(14)
  ) u_buf (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_valid(push),
    .o_ready(buf_ready),
    .i_data({pend_over, pend_data}),
    .o_valid(o_result_valid),
    .i_ready(i_result_ready),
    .o_data(buf_out)
  );
endmodule // sdra_decimator

// ---- tb/sdra_mod_src.sv ----
`timescale 1ns/10ps
// Shorted input while calibrating gives a zero-mean stream; line churns between samples
module sdra_mod_src (
  input wire i_clk_sys,
  input wire i_sample,
  input wire i_cal,
  input wire i_level,
  output wire o_bit
);
  logic alt = 1'b0;
  logic junk = 1'b0;
  assign o_bit = i_sample ? (i_cal ? alt : i_level) : junk;
  always @(posedge i_clk_sys) begin
    junk <= ~junk;
    if (i_sample) alt <= ~alt;
  end
endmodule // sdra_mod_src

// ---- tb/sdra_decimator_chk.sv ----
`timescale 1ns/10ps
module sdra_decimator_chk #(
  parameter [15:0] EXT_CONV_CYCLES = 16'h0190
) (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_mod_bit,
  input wire i_ext_clk,
  input wire i_ext_clk_sel,
  input wire [1:0] i_notch_sel,
  input wire i_double_speed,
  input wire o_mod_sample,
  input wire o_cal_phase,
  input wire o_result_valid,
  input wire i_result_ready,
  input wire [12:0] o_result_data,
  input wire o_over_range
);
  int gap;
  int lo;
  logic ok;
  logic [1:0] up;
  logic [2:0] cfg;
  logic [12:0] mag;
  wire st = ok && !i_ext_clk_sel && cfg == {i_ext_clk_sel, i_notch_sel};
  // Fractional rate: a gap may be one cycle longer than the floor value
  assign lo = (i_notch_sel == 2'h1) ? 780 : (i_notch_sel == 2'h2) ? 650 : 715;
  assign mag = o_result_data[12] ? -o_result_data : o_result_data;
  always @(posedge i_clk_sys) begin
    cfg <= {i_ext_clk_sel, i_notch_sel};
    if (i_rst) begin
      gap <= 0;
      ok <= 1'b0;
      up <= 2'h0;
    end else begin
      gap <= o_mod_sample ? 0 : gap + 1;
      ok <= (o_mod_sample || ok) && st | (o_mod_sample && cfg == {i_ext_clk_sel, i_notch_sel});
      if (up != 2'h3) up <= up + 2'h1;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  pulse_gap_a: assert property (o_mod_sample |=> !o_mod_sample)
    else $error("sample pulses back to back");
  rate_exact_a: assert property (st && o_mod_sample |-> gap == lo || gap == lo + 1)
    else $error("sample period off");
  rate_live_a: assert property (st |-> gap <= lo + 1)
    else $error("sample pulse missing");
  valid_hold_a: assert property (o_result_valid && !i_result_ready |=>
    o_result_valid && $stable(o_result_data)) else $error("result not held");
  sat_lim_a: assert property (o_result_valid |-> mag <= 13'h0600)
    else $error("result beyond saturation");
  over_flag_a: assert property (o_result_valid |-> o_over_range == (mag > 13'h0400))
    else $error("over range flag wrong");
  cal_skip_a: assert property (up == 2'h3 && i_double_speed && $past(i_double_speed) &&
    $past(i_double_speed, 2) && $past(i_double_speed, 3) |-> !o_cal_phase)
    else $error("calibration in double speed");
  rst_out_a: assert property ($fell(i_rst) |-> o_cal_phase && !o_result_valid)
    else $error("outputs after reset wrong");
endmodule // sdra_decimator_chk

// ---- tb/sdra_decimator_tb.sv ----
`timescale 1ns/10ps
`include "sdra_map.vh"
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %0d seen %0d", n, e, a); end end
module sdra_decimator_tb;
  logic i_clk_sys = 0, i_rst = 1, i_ext_clk = 0, i_ext_clk_sel = 0, lvl = 1;
  logic i_double_speed = 0, i_result_ready = 0;
  logic [1:0] i_notch_sel = 2'h0;
  wire i_mod_bit, o_mod_sample, o_cal_phase, o_result_valid, o_over_range;
  wire [12:0] o_result_data;
  int miscompares = 0, num_checks = 0, cyc = 0;
  initial forever #50 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) cyc <= cyc + 1;
  // Six-cycle period keeps the synchroniser well clear of missing edges
  always begin
    repeat (3) @(posedge i_clk_sys);
    i_ext_clk <= ~i_ext_clk;
  end
  sdra_decimator #(.EXT_CONV_CYCLES(16'h0190)) sdra_decimator_inst (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_mod_bit(i_mod_bit), .i_ext_clk(i_ext_clk), .i_ext_clk_sel(i_ext_clk_sel),
    .i_notch_sel(i_notch_sel), .i_double_speed(i_double_speed), .o_mod_sample(o_mod_sample),
    .o_cal_phase(o_cal_phase), .o_result_valid(o_result_valid),
    .i_result_ready(i_result_ready), .o_result_data(o_result_data),
    .o_over_range(o_over_range));
  sdra_mod_src sdra_mod_src_inst (.i_clk_sys(i_clk_sys), .i_sample(o_mod_sample),
    .i_cal(o_cal_phase), .i_level(lvl), .o_bit(i_mod_bit));
  task automatic close_out;
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic take(input logic [12:0] e, output int t);
    int n = 0;
    do begin
      @(negedge i_clk_sys);
      n++;
      if (n > 9000) begin miscompares++; close_out(); end
    end while (o_result_valid !== 1'b1);
    t = cyc;
    `CHK("result", e, o_result_data)
    `CHK("over", 1'b0, o_over_range)
    @(posedge i_clk_sys) i_result_ready <= 1'b1;
    @(posedge i_clk_sys) i_result_ready <= 1'b0;
  endtask
  task automatic rate(input logic [1:0] s, input int fs);
    int n = 0;
    @(posedge i_clk_sys) i_notch_sel <= s;
    repeat (800) @(posedge i_clk_sys);
    repeat (10000) begin @(negedge i_clk_sys); n += o_mod_sample; end
    `CHK("rate", 1, n == fs / 1000 || n == fs / 1000 + 1)
  endtask
  task automatic ext_count;
    int n = 0;
    @(posedge i_clk_sys) i_ext_clk_sel <= 1'b1;
    repeat (300) @(posedge i_clk_sys);
    repeat (1200) begin @(negedge i_clk_sys); n += o_mod_sample; end
    `CHK("ext rate", 10, n)
  endtask
  task automatic conv_1x;
    int t1, t2;
    take(13'h000A, t1);
    take(13'h000A, t2);
    `CHK("1x span", 1, t2 - t1 >= 2395 && t2 - t1 <= 2410)
  endtask
  task automatic conv_2x;
    int t1, t2;
    @(posedge i_clk_sys) i_double_speed <= 1'b1;
    take(13'h000A, t1);
    lvl <= 1'b0;
    take(13'h0000, t2);
    `CHK("2x span", 1, t2 - t1 >= 1195 && t2 - t1 <= 1210)
    take(13'h1FF6, t1);
  endtask
  // Two buffered words plus the one parked in the engine must all survive
  task automatic stall;
    int n = 0;
    repeat (6000) @(posedge i_clk_sys);
    i_result_ready <= 1'b1;
    repeat (30) begin
      @(negedge i_clk_sys);
      if (o_result_valid === 1'b1) begin
        n++;
        `CHK("drain", 13'h1FF6, o_result_data)
      end
    end
    `CHK("drained", 3, n)
    @(posedge i_clk_sys) i_result_ready <= 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rate(2'h1, `SDRA_FS_50HZ);
    rate(2'h0, `SDRA_FS_5060HZ);
    rate(2'h2, `SDRA_FS_60HZ);
    rate(2'h3, `SDRA_FS_5060HZ);
    ext_count();
    conv_1x();
    conv_2x();
    stall();
    close_out();
  end
endmodule // sdra_decimator_tb
bind sdra_decimator sdra_decimator_chk #(.EXT_CONV_CYCLES(EXT_CONV_CYCLES)) chk_inst (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_mod_bit(i_mod_bit), .i_ext_clk(i_ext_clk),
  .i_ext_clk_sel(i_ext_clk_sel), .i_notch_sel(i_notch_sel), .i_double_speed(i_double_speed),
  .o_mod_sample(o_mod_sample), .o_cal_phase(o_cal_phase), .o_result_valid(o_result_valid),
  .i_result_ready(i_result_ready), .o_result_data(o_result_data),
  .o_over_range(o_over_range));
